/* rtl/tmbc_ctrl.sv */
// sequential message buffer and mode control of a buffered terminal
`timescale 1ns/1ps
`include "tmbc_map.svh"

module tmbc_ctrl #(
    parameter int          DEPTH       = `TMBC_DEPTH,
    parameter int unsigned TIMEOUT_CYC = `TMBC_TIMEOUT_CYC,
    parameter logic [15:0] BIT_CYC     = `TMBC_BIT_CYC,
    parameter logic [6:0]  DOWNSHIFT   = `TMBC_CODE_DOWNSHIFT,
    parameter logic [6:0]  STOP        = `TMBC_CODE_STOP,
    parameter logic [6:0]  STOP_ALT    = `TMBC_CODE_STOP_ALT,
    parameter logic [6:0]  BKSP        = `TMBC_CODE_BKSP
) (
    // clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_rstn,
    // operator pins and option straps
    input  wire logic                    i_enter_key,
    input  wire logic                    i_bid_key,
    input  wire logic                    i_reset_key,
    input  wire logic                    i_local_mode,
    input  wire logic                    i_printer_upper,
    input  wire logic                    i_opt_bufrx,
    input  wire logic                    i_opt_recchk,
    input  wire logic                    i_timeout_en,
    // keyboard characters
    input  wire logic                    i_key_valid,
    input  wire logic [`TMBC_CHAR_W-1:0] i_key_char,
    // line side
    input  wire logic                    i_poll,
    input  wire logic                    i_rx_valid,
    input  wire logic [`TMBC_CHAR_W-1:0] i_rx_char,
    input  wire logic                    i_rx_msg_end,
    // printer side
    input  wire logic                    i_print_ready,
    output logic                         o_print_valid,
    output logic [`TMBC_CHAR_W-1:0]      o_print_char,
    // line outputs
    output logic                         o_line_tx,
    output logic                         o_line_bid,
    output logic                         o_tx_mode,
    // operator outputs
    output logic                         o_enter_light,
    output logic                         o_reset_light,
    output logic                         o_kbd_lock,
    output logic                         o_kbd_downshift,
    output logic                         o_motor_on
);
    import tmbc_pkg::*;

    localparam logic [`TMBC_ADDR_W-1:0] LAST    = `TMBC_ADDR_W'(DEPTH - 1);
    localparam logic [`TMBC_ADDR_W-1:0] LOCK_AT = `TMBC_ADDR_W'(DEPTH - `TMBC_LOCK_MARGIN);

    tmbc_regs_t s;
    tmbc_regs_t n;

    // ==========================================================
    // buffer storage
    logic [`TMBC_CHAR_W-1:0] mem [DEPTH];
    logic                    we;
    logic [`TMBC_CHAR_W-1:0] wd;
    logic [`TMBC_CHAR_W-1:0] rd;
    logic                    tmo;

    assign rd = mem[s.addr];

    always_ff @(posedge i_clk) begin
        if (we) begin
            mem[s.addr] <= wd;
        end
    end

    // ==========================================================
    // synchronised pin levels and edges
    logic                   lcl;
    logic                   upr;
    logic                   enter_e;
    logic                   bid_e;
    logic                   reset_e;
    logic [`TMBC_CHAR_W-1:0] stop_code;

    assign lcl       = s.sync2[`TMBC_PIN_LOCAL];
    assign upr       = s.sync2[`TMBC_PIN_UPPER];
    assign enter_e   = s.sync2[`TMBC_PIN_ENTER] & ~s.prev[`TMBC_PIN_ENTER];
    assign bid_e     = s.sync2[`TMBC_PIN_BID] & ~s.prev[`TMBC_PIN_BID];
    assign reset_e   = s.sync2[`TMBC_PIN_RESET] & ~s.prev[`TMBC_PIN_RESET];
    assign stop_code = s.sync2[`TMBC_PIN_RECCHK] ? STOP_ALT : STOP;

    function automatic logic [`TMBC_ADDR_W-1:0] step(input logic [`TMBC_ADDR_W-1:0] a);
        // saturate at the last location so a runaway stream cannot wrap
        step = (a == LAST) ? a : a + `TMBC_ADDR_W'(1);
    endfunction

    // ==========================================================
    // enter timeout
    tmbc_gap_timer #(
        .CYC (TIMEOUT_CYC)
    ) u_gap (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .i_run    (s.st == ST_ENTER && !lcl && s.sync2[`TMBC_PIN_TMOEN]),
        .i_kick   (i_key_valid | enter_e | bid_e | reset_e),
        .o_expire (tmo)
    );

    // ==========================================================
    // next state
    always_comb begin
        n = s;
        we = 1'b0;
        wd = s.phr;
        n.sync1 = {i_timeout_en, i_opt_recchk, i_opt_bufrx, i_printer_upper,
                   i_local_mode, i_reset_key, i_bid_key, i_enter_key};
        n.sync2 = s.sync1;
        n.prev = s.sync2;
        n.downshift = 1'b0;
        n.key_wr = 1'b0;
        n.rx_step = 1'b0;
        n.rx_wr = 1'b0;
        n.tx_ld = 1'b0;

        // shift chain, one bit per line bit time
        if (s.sh_busy) begin
            if (s.baud == 16'h0000) begin
                n.baud = BIT_CYC - 16'h0001;
                if (s.bitcnt == 4'h0) begin
                    n.sh_busy = 1'b0;
                    n.line_tx = 1'b1;
                end else begin
                    n.line_tx = s.shreg[0];
                    n.shreg = {1'b1, s.shreg[8:1]};
                    n.bitcnt = s.bitcnt - 4'h1;
                end
            end else begin
                n.baud = s.baud - 16'h0001;
            end
        end
        if (s.tx_ld) begin
            n.shreg = {1'b1, s.thr, 1'b0};
            n.bitcnt = 4'h9;
            n.baud = 16'h0000;
            n.sh_busy = 1'b1;
            n.addr = step(s.addr);
        end

        if (s.print_valid && i_print_ready) begin
            n.print_valid = 1'b0;
        end

        // receive path through both holding registers
        if (i_rx_valid && (s.st == ST_IDLE || s.st == ST_RX_BUF)) begin
            n.thr = i_rx_char;
            n.rx_step = 1'b1;
        end
        if (s.rx_step) begin
            n.phr = s.thr;
            if (s.sync2[`TMBC_PIN_BUFRX]) begin
                n.rx_wr = 1'b1;
                if (s.st == ST_IDLE) begin
                    n.st = ST_RX_BUF;
                    n.addr = '0;
                end
            end else begin
                n.print_valid = 1'b1;
            end
        end
        if (s.rx_wr) begin
            we = 1'b1;
            n.addr = step(s.addr);
        end

        unique case (s.st)
            ST_IDLE: begin
                if (enter_e) begin
                    n.st = ST_ENTER;
                    n.addr = '0;
                    n.enter_light = 1'b1;
                    n.motor = 1'b1;
                    n.kbd_lock = 1'b0;
                    n.reset_light = 1'b0;
                    n.downshift = upr;
                end
            end
            ST_ENTER: begin
                if (i_key_valid && !s.kbd_lock) begin
                    n.phr = i_key_char;
                    n.key_wr = 1'b1;
                end
                if (s.key_wr) begin
                    if (s.phr == BKSP) begin
                        if (s.addr != '0) begin
                            n.addr = s.addr - `TMBC_ADDR_W'(1);
                        end
                        n.kbd_lock = s.reset_light;
                    end else begin
                        we = 1'b1;
                        n.addr = step(s.addr);
                        if (!(^s.phr)) begin
                            n.kbd_lock = 1'b1;
                            n.reset_light = 1'b1;
                        end
                    end
                end else if (bid_e) begin
                    n.st = ST_BID_STOP;
                    n.kbd_lock = 1'b1;
                    if (upr) begin
                        wd = DOWNSHIFT;
                        we = 1'b1;
                        n.addr = step(s.addr);
                        n.downshift = 1'b1;
                    end
                end
            end
            ST_BID_STOP: begin
                wd = stop_code;
                we = 1'b1;
                if (lcl) begin
                    n.st = ST_PRINT;
                    n.addr = '0;
                end else begin
                    n.st = ST_BID_WAIT;
                    n.line_bid = 1'b1;
                end
            end
            ST_BID_WAIT: begin
                if (lcl && bid_e) begin
                    n.st = ST_PRINT;
                    n.line_bid = 1'b0;
                    n.addr = '0;
                end else if (!lcl && i_poll) begin
                    n.st = ST_TX_REPLY;
                    n.tx_mode = 1'b1;
                    n.line_bid = 1'b0;
                    n.thr = stop_code;
                    n.tx_ld = 1'b1;
                end
            end
            ST_TX_REPLY: begin
                if (!s.sh_busy && !s.tx_ld) begin
                    n.st = ST_TX_DATA;
                    n.addr = '0;
                    n.tx_last = 1'b0;
                end
            end
            ST_TX_DATA: begin
                if (!s.sh_busy && !s.tx_ld) begin
                    if (s.tx_last) begin
                        n.st = ST_IDLE;
                        n.tx_mode = 1'b0;
                        n.enter_light = 1'b0;
                        n.kbd_lock = 1'b0;
                    end else begin
                        n.thr = rd;
                        n.tx_ld = 1'b1;
                        n.tx_last = (rd == stop_code) || (s.addr == LAST);
                    end
                end
            end
            ST_PRINT: begin
                if (!s.print_valid) begin
                    if (rd == stop_code || s.addr == LAST) begin
                        n.st = ST_ENTER;
                        n.enter_light = 1'b1;
                        n.kbd_lock = s.reset_light;
                        if (upr) begin
                            wd = DOWNSHIFT;
                            we = 1'b1;
                            n.addr = step(s.addr);
                            n.downshift = 1'b1;
                        end
                    end else begin
                        n.phr = rd;
                        n.print_valid = 1'b1;
                        n.addr = step(s.addr);
                    end
                end
            end
            ST_RX_BUF: begin
                if (i_rx_msg_end && !s.rx_step && !s.rx_wr) begin
                    n.st = ST_RX_PRINT;
                    n.rx_len = s.addr;
                    n.addr = '0;
                end
            end
            ST_RX_PRINT: begin
                if (!s.print_valid) begin
                    if (s.addr == s.rx_len) begin
                        n.st = ST_IDLE;
                    end else begin
                        n.phr = rd;
                        n.print_valid = 1'b1;
                        n.addr = step(s.addr);
                    end
                end
            end
        endcase

        // transmit runs to its end; the line cannot be abandoned mid message
        if ((reset_e || tmo) && s.st != ST_TX_REPLY && s.st != ST_TX_DATA) begin
            n.st = ST_IDLE;
            n.addr = '0;
            n.enter_light = 1'b0;
            n.reset_light = 1'b0;
            n.kbd_lock = 1'b0;
            n.line_bid = 1'b0;
            n.key_wr = 1'b0;
        end
        if (n.st == ST_ENTER && n.addr >= LOCK_AT) begin
            n.kbd_lock = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s <= '0;
            s.line_tx <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // ==========================================================
    // outputs
    assign o_print_valid   = s.print_valid;
    assign o_print_char    = s.phr;
    assign o_line_tx       = s.line_tx;
    assign o_line_bid      = s.line_bid;
    assign o_tx_mode       = s.tx_mode;
    assign o_enter_light   = s.enter_light;
    assign o_reset_light   = s.reset_light;
    assign o_kbd_lock      = s.kbd_lock;
    assign o_kbd_downshift = s.downshift;
    assign o_motor_on      = s.motor;

    // ==========================================================
    // checks
    enter_entry_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (s.st == ST_IDLE && enter_e && !reset_e && !tmo) |=>
        (s.st == ST_ENTER && s.addr == '0 && s.enter_light && s.motor))
        else $error("enter entry wrong");
    enter_downshift_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (s.st == ST_IDLE && enter_e && upr) |=> s.downshift)
        else $error("no downshift on enter");
    store_step_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (s.st == ST_ENTER && s.key_wr && s.phr != BKSP && s.addr != LAST
         && !reset_e && !tmo) |=> s.addr == $past(s.addr) + `TMBC_ADDR_W'(1))
        else $error("store did not step");
    bksp_back_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (s.st == ST_ENTER && s.key_wr && s.phr == BKSP && s.addr != '0
         && !reset_e && !tmo) |=> s.addr == $past(s.addr) - `TMBC_ADDR_W'(1))
        else $error("backspace did not step back");
    parity_check_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (s.st == ST_ENTER && s.key_wr && s.phr != BKSP && !(^s.phr)
         && !reset_e && !tmo) |=> (s.kbd_lock && s.reset_light))
        else $error("even parity not flagged");
    kbd_lock_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (s.st == ST_ENTER && s.addr >= LOCK_AT) |-> s.kbd_lock)
        else $error("keyboard open near end");
    line_bid_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (s.st == ST_BID_STOP && !lcl && !reset_e && !tmo) |=>
        (s.line_bid && s.st == ST_BID_WAIT))
        else $error("no line bid");
    tx_rewind_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (s.st == ST_TX_REPLY ##1 s.st == ST_TX_DATA) |-> s.addr == '0)
        else $error("transmit not rewound");
    start_bit_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(s.sh_busy) |=> !s.line_tx)
        else $error("no start bit");
    rx_route_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (s.rx_step && !s.sync2[`TMBC_PIN_BUFRX]) |=> (s.print_valid && s.phr == $past(s.thr)))
        else $error("receive not printed");
    rx_buffer_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (s.rx_step && s.sync2[`TMBC_PIN_BUFRX]) |=> s.rx_wr)
        else $error("receive not buffered");
    reset_key_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (reset_e && s.st != ST_TX_REPLY && s.st != ST_TX_DATA) |=>
        (s.st == ST_IDLE && s.addr == '0 && !s.enter_light))
        else $error("reset key ignored");

endmodule // tmbc_ctrl

/* rtl/tmbc_gap_timer.sv */
// gap timer that expires when no operator action comes in time
`timescale 1ns/1ps
`include "tmbc_map.svh"

module tmbc_gap_timer #(
    parameter int unsigned CYC = `TMBC_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // control
    input  wire logic i_run,
    input  wire logic i_kick,
    // event
    output logic      o_expire
);
    import tmbc_pkg::*;

    tmbc_tmr_t t_reg;
    tmbc_tmr_t t_next;

    // ==========================================================
    // counting
    always_comb begin
        t_next        = t_reg;
        t_next.expire = 1'b0;
        if (!i_run || i_kick) begin
            t_next.cnt = 32'h0000_0000;
        end else if (t_reg.cnt == 32'(CYC - 1)) begin
            t_next.cnt    = 32'h0000_0000;
            t_next.expire = 1'b1;
        end else begin
            t_next.cnt = t_reg.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign o_expire = t_reg.expire;

endmodule // tmbc_gap_timer

/* rtl/tmbc_map.svh */
// constants of the terminal message buffer control
`ifndef TMBC_MAP_SVH
`define TMBC_MAP_SVH

// ==========================================================
// geometry
`define TMBC_CHAR_W      7
`define TMBC_ADDR_W      9
`define TMBC_DEPTH       448
`define TMBC_LOCK_MARGIN 8

// ==========================================================
// character codes (plain defaults, not taken from any part)
`define TMBC_CODE_DOWNSHIFT 7'h1C
`define TMBC_CODE_STOP      7'h1F
`define TMBC_CODE_STOP_ALT  7'h31
`define TMBC_CODE_BKSP      7'h5D

// ==========================================================
// timing
`define TMBC_CLK_HZ      100000000
`define TMBC_TIMEOUT_S   15
`define TMBC_TIMEOUT_CYC (`TMBC_TIMEOUT_S * `TMBC_CLK_HZ)
`define TMBC_BIT_CYC     16'h03E8

// ==========================================================
// synchronised pin positions
`define TMBC_PIN_N      8
`define TMBC_PIN_ENTER  0
`define TMBC_PIN_BID    1
`define TMBC_PIN_RESET  2
`define TMBC_PIN_LOCAL  3
`define TMBC_PIN_UPPER  4
`define TMBC_PIN_BUFRX  5
`define TMBC_PIN_RECCHK 6
`define TMBC_PIN_TMOEN  7

`endif

/* rtl/tmbc_pkg.sv */
// types of the terminal message buffer control
`include "tmbc_map.svh"

package tmbc_pkg;

    // ==========================================================
    // control states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ENTER,
        ST_BID_STOP,
        ST_BID_WAIT,
        ST_TX_REPLY,
        ST_TX_DATA,
        ST_PRINT,
        ST_RX_BUF,
        ST_RX_PRINT
    } tmbc_state_t;

    // ==========================================================
    // register state of the main block
    typedef struct packed {
        tmbc_state_t                st;
        logic [`TMBC_PIN_N-1:0]     sync1;
        logic [`TMBC_PIN_N-1:0]     sync2;
        logic [`TMBC_PIN_N-1:0]     prev;
        logic [`TMBC_ADDR_W-1:0]    addr;
        logic [`TMBC_ADDR_W-1:0]    rx_len;
        logic [`TMBC_CHAR_W-1:0]    thr;
        logic [`TMBC_CHAR_W-1:0]    phr;
        logic                       key_wr;
        logic                       rx_step;
        logic                       rx_wr;
        logic                       tx_ld;
        logic                       tx_last;
        logic [8:0]                 shreg;
        logic [3:0]                 bitcnt;
        logic [15:0]                baud;
        logic                       sh_busy;
        logic                       line_tx;
        logic                       print_valid;
        logic                       enter_light;
        logic                       reset_light;
        logic                       kbd_lock;
        logic                       downshift;
        logic                       motor;
        logic                       line_bid;
        logic                       tx_mode;
    } tmbc_regs_t;

    // ==========================================================
    // state of the gap timer
    typedef struct packed {
        logic [31:0] cnt;
        logic        expire;
    } tmbc_tmr_t;

endpackage

/* tb/tmbc_ctrl_tb.sv */
// self-checking bench of the terminal message buffer control
`timescale 1ns/1ps
`include "tmbc_map.svh"

module tmbc_ctrl_tb;
    logic       i_clk, i_rstn, i_local_mode, i_printer_upper, i_opt_recchk, i_timeout_en;
    logic       i_key_valid, i_poll, i_rx_valid, i_print_ready, i_opt_bufrx, i_rx_msg_end;
    logic [2:0] key;
    logic [6:0] i_key_char, i_rx_char, o_print_char;
    logic       o_print_valid, o_line_tx, o_line_bid, o_tx_mode, o_enter_light;
    logic       o_reset_light, o_kbd_lock, o_kbd_downshift, o_motor_on;
    int         n_mismatch, samples_checked, n_dshift;
    int         mq[$];

    // ==========================================
    // design and far side
    tmbc_ctrl #(.TIMEOUT_CYC(200), .BIT_CYC(16'h0004)) i_tmbc_ctrl (.i_clk, .i_rstn,
        .i_enter_key(key[0]), .i_bid_key(key[1]), .i_reset_key(key[2]), .i_local_mode,
        .i_printer_upper, .i_opt_bufrx, .i_opt_recchk, .i_timeout_en, .i_key_valid,
        .i_key_char, .i_poll, .i_rx_valid, .i_rx_char, .i_rx_msg_end, .i_print_ready,
        .o_print_valid, .o_print_char, .o_line_tx, .o_line_bid, .o_tx_mode, .o_enter_light,
        .o_reset_light, .o_kbd_lock, .o_kbd_downshift, .o_motor_on);
    tmbc_host #(.BIT(4), .POLL_DLY(7)) i_tmbc_host (.i_clk, .i_bid(o_line_bid),
        .i_line(o_line_tx), .o_poll(i_poll));

    // ==========================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic chk(input logic [6:0] got, input int exp);
        samples_checked++;
        if (got !== exp[6:0]) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp[6:0]);
        end
    endtask
    task automatic press(input int k);
        key[k] = 1'b1;
        cyc(6);
        key[k] = 1'b0;
        cyc(6);
    endtask
    task automatic type_c(input logic [6:0] c);
        i_key_char = c;
        i_key_valid = 1'b1;
        cyc(1);
        i_key_valid = 1'b0;
        cyc(3);
        if (c === `TMBC_CODE_BKSP) void'(mq.pop_back());
        else mq.push_back(c);
    endtask
    // odd parity, values kept clear of the control codes
    function automatic logic [6:0] rnd_c();
        logic [5:0] d;
        d = 6'($urandom_range(15));
        return {~^d, d};
    endfunction
    task automatic msg(input int n);
        mq = {};
        press(0);
        for (int i = 0; i < n; i++) begin
            type_c(rnd_c());
            if (i == 1) type_c(`TMBC_CODE_BKSP);
        end
    endtask
    task automatic take(input int exp);
        int t;
        for (t = 0; t < 300 && o_print_valid !== 1'b1; t++) cyc(1);
        chk(7'(o_print_valid), 1);
        cyc($urandom_range(3));
        chk(o_print_char, exp);
        i_print_ready = 1'b1;
        cyc(1);
        i_print_ready = 1'b0;
        cyc(1);
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================
    // clock, watchdog, tests
    // downshift is a one-cycle pulse, so count it where it is settled
    always @(negedge i_clk) begin
        if (o_kbd_downshift === 1'b1) n_dshift++;
    end
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        cyc(20000);
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        logic [6:0] c;
        int t;
        {i_rstn, key, i_key_valid, i_rx_valid, i_print_ready, i_local_mode} = '0;
        {i_opt_bufrx, i_rx_msg_end} = 2'h0;
        {i_printer_upper, i_opt_recchk, i_timeout_en} = 3'h7;
        {i_key_char, i_rx_char} = '0;
        void'($urandom(38));
        cyc(2);
        i_rstn = 1'b1;
        cyc(2);
        msg(5);
        chk(7'(o_enter_light), 1);
        chk(7'(o_motor_on), 1);
        chk(7'(n_dshift), 1);
        press(1);
        mq.push_back(`TMBC_CODE_DOWNSHIFT);
        mq.push_back(`TMBC_CODE_STOP_ALT);
        mq.push_front(`TMBC_CODE_STOP_ALT);
        for (t = 0; t < 300 && o_tx_mode !== 1'b1; t++) cyc(1);
        for (t = 0; t < 3000 && o_tx_mode !== 1'b0; t++) cyc(1);
        chk(7'(i_tmbc_host.got_q.size()), mq.size());
        foreach (mq[i]) chk(i_tmbc_host.got_q[i], mq[i]);
        chk(7'(n_dshift), 2);
        $display("test transmit done");
        c = rnd_c();
        i_rx_char = c;
        i_rx_valid = 1'b1;
        cyc(1);
        i_rx_valid = 1'b0;
        take(c);
        $display("test receive done");
        i_opt_bufrx = 1'b1;
        mq = {};
        cyc(3);
        for (int i = 0; i < 3; i++) begin
            c = rnd_c();
            mq.push_back(c);
            i_rx_char = c;
            i_rx_valid = 1'b1;
            cyc(1);
            i_rx_valid = 1'b0;
            cyc(3);
            chk(7'(o_print_valid), 0);
        end
        i_rx_msg_end = 1'b1;
        cyc(1);
        i_rx_msg_end = 1'b0;
        foreach (mq[i]) take(mq[i]);
        $display("test buffered receive done");
        press(0);
        type_c(7'h03);
        chk({o_kbd_lock, o_reset_light}, 3);
        press(2);
        chk({o_enter_light, o_reset_light}, 0);
        press(0);
        cyc(300);
        chk(7'(o_enter_light), 0);
        $display("test check reset timeout done");
        press(0);
        repeat (439) type_c(rnd_c());
        chk(7'(o_kbd_lock), 0);
        type_c(rnd_c());
        chk(7'(o_kbd_lock), 1);
        press(2);
        $display("test lock near end done");
        {i_local_mode, i_printer_upper, i_opt_recchk} = 3'h6;
        msg(4);
        press(1);
        mq.push_back(`TMBC_CODE_DOWNSHIFT);
        foreach (mq[i]) take(mq[i]);
        cyc(4);
        chk({o_enter_light, o_kbd_lock}, 2);
        chk(7'(n_dshift), 8);
        $display("test local print done");
        report_and_stop();
    end
endmodule // tmbc_ctrl_tb

/* tb/tmbc_host.sv */
// polling processor model: polls a bidding terminal and deserialises its line
`timescale 1ns/1ps

module tmbc_host #(
    parameter int BIT      = 4,
    parameter int POLL_DLY = 7
) (
    // clock
    input  wire logic i_clk,
    // line from the terminal
    input  wire logic i_bid,
    input  wire logic i_line,
    // poll to the terminal
    output logic      o_poll
);
    logic [6:0] got_q[$];

    // ==========================================
    // poll and receive
    initial begin
        logic [6:0] c;
        o_poll = 1'b0;
        forever begin
            @(negedge i_clk);
            if (i_bid === 1'b1) begin
                // a slow poll: the terminal must keep bidding meanwhile
                repeat (POLL_DLY) @(negedge i_clk);
                o_poll = 1'b1;
                @(negedge i_clk);
                o_poll = 1'b0;
            end
            if (i_line === 1'b0) begin
                // sample near the middle of each data bit
                repeat (BIT + BIT / 2 - 1) @(negedge i_clk);
                for (int b = 0; b < 7; b++) begin
                    c[b] = i_line;
                    repeat (BIT) @(negedge i_clk);
                end
                got_q.push_back(c);
            end
        end
    end
endmodule // tmbc_host
